//--- acc_regs.svh
// Register map, field positions and coefficient constants of the calibration coefficient block
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH

`define ACC_ADDR_W        4
`define ACC_DATA_W        8
`define ACC_COEF_W        24

`define ACC_OFS_OFF_HIGH  4'h0
`define ACC_OFS_OFF_MID   4'h1
`define ACC_OFS_OFF_LOW   4'h2
`define ACC_OFS_GAIN_HIGH 4'h3
`define ACC_OFS_GAIN_MID  4'h4
`define ACC_OFS_GAIN_LOW  4'h5
`define ACC_OFS_STATUS    4'h6
`define ACC_OFS_CLEAR     4'h7
`define ACC_OFS_ENABLE    4'h8

`define ACC_BYTE_HIGH     2'h0
`define ACC_BYTE_MID      2'h1
`define ACC_BYTE_LOW      2'h2

`define ACC_LANE_HIGH_LSB 16
`define ACC_LANE_MID_LSB  8
`define ACC_LANE_LOW_LSB  0

`define ACC_OFF_RESET     24'h000000
`define ACC_GAIN_RESET    24'h800000
`define ACC_OFF_MAX       24'h7fffff
`define ACC_OFF_MIN       24'h800000
`define ACC_GAIN_MIN      24'h000000
`define ACC_GAIN_MAX      24'hffffff
`define ACC_GAIN_FRAC     23

`define ACC_ST_W          4
`define ACC_ST_CAL_DONE   0
`define ACC_ST_OFF_ERR    1
`define ACC_ST_GAIN_ERR   2
`define ACC_ST_SAT        3
`define ACC_ST_RESET      4'h0

`endif

//--- acc_pkg.sv
// Types shared by the calibration coefficient block
package acc_pkg;
  typedef enum logic [0:0] {
    ACC_CAL_OFFSET = 1'b0,
    ACC_CAL_GAIN   = 1'b1
  } acc_cal_kind_type;

  typedef logic [23:0] acc_coef_type;
endpackage

//--- acc_coef_if.sv
// Coefficient link from the register file to the conversion corrector
`timescale 1ns/100ps
interface acc_coef_if;
  acc_pkg::acc_coef_type offset;
  acc_pkg::acc_coef_type gain;
  modport owner (output offset, output gain);
  modport user  (input offset, input gain);
endinterface

//--- acc_cal_check.sv
// Classifies a finished calibration result: load strobes and extreme-value errors
`timescale 1ns/100ps
`include "acc_regs.svh"
module acc_cal_check (
  input  wire logic                     i_done,
  input  wire acc_pkg::acc_cal_kind_type i_kind,
  input  wire acc_pkg::acc_coef_type    i_result,
  output logic                          o_off_load,
  output logic                          o_gain_load,
  output logic                          o_off_err,
  output logic                          o_gain_err
);
  function automatic logic at_limit(input acc_pkg::acc_coef_type v,
                                    input acc_pkg::acc_coef_type lo,
                                    input acc_pkg::acc_coef_type hi);
    at_limit = (v == lo) || (v == hi);
  endfunction

  always_comb begin
    o_off_load  = i_done && (i_kind == acc_pkg::ACC_CAL_OFFSET);
    o_gain_load = i_done && (i_kind == acc_pkg::ACC_CAL_GAIN);
    o_off_err   = o_off_load && at_limit(i_result, `ACC_OFF_MIN, `ACC_OFF_MAX);
    o_gain_err  = o_gain_load && at_limit(i_result, `ACC_GAIN_MIN, `ACC_GAIN_MAX);
  end
endmodule

//--- acc_corrector.sv
// Two-stage conversion correction: subtract offset, then scale by gain
`timescale 1ns/100ps
`include "acc_regs.svh"
module acc_corrector #(
  parameter int RES_BITS = 24
) (
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_resetn,
  acc_coef_if.user                   coef,
  input  wire logic                  i_valid,
  input  wire logic [RES_BITS-1:0]   i_raw,
  output logic                       o_valid,
  output logic [`ACC_COEF_W-1:0]     o_data,
  output logic                       o_sat
);
  localparam int PW = 2 * (`ACC_COEF_W + 1);

  logic [RES_BITS+`ACC_COEF_W-1:0] raw_wide;
  logic signed [`ACC_COEF_W-1:0]   raw_al;
  logic signed [`ACC_COEF_W:0]     diff_d;
  logic signed [`ACC_COEF_W:0]     diff_q;
  logic                            v1_q;
  logic signed [PW-1:0]            prod;
  logic signed [PW-`ACC_GAIN_FRAC-1:0] scaled;
  logic [`ACC_COEF_W-1:0]          sat_d;
  logic                            sat_flag;

  // Left-align the sample so a 16-bit result puts its low offset byte below one LSB
  assign raw_wide = {i_raw, `ACC_COEF_W'(0)};
  assign raw_al   = raw_wide[RES_BITS+`ACC_COEF_W-1 -: `ACC_COEF_W];
  assign diff_d   = {raw_al[`ACC_COEF_W-1], raw_al}
                  - {coef.offset[`ACC_COEF_W-1], coef.offset};

  // Gain is unsigned, so a zero is put above it before the signed product
  assign prod   = PW'(diff_q * $signed({1'b0, coef.gain}));
  assign scaled = prod[PW-1:`ACC_GAIN_FRAC];

  always_comb begin
    sat_flag = 1'b0;
    sat_d    = scaled[`ACC_COEF_W-1:0];
    if (scaled > $signed(PW'(`ACC_OFF_MAX))) begin
      sat_flag = 1'b1;
      sat_d    = `ACC_OFF_MAX;
    end else if (scaled < -$signed(PW'(`ACC_OFF_MIN))) begin
      sat_flag = 1'b1;
      sat_d    = `ACC_OFF_MIN;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      diff_q <= '0;
      v1_q   <= 1'b0;
    end else begin
      v1_q   <= i_valid;
      if (i_valid) begin
        diff_q <= diff_d;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_valid <= 1'b0;
      o_data  <= '0;
      o_sat   <= 1'b0;
    end else begin
      o_valid <= v1_q;
      o_sat   <= v1_q && sat_flag;
      if (v1_q) begin
        o_data <= sat_d;
      end
    end
  end
endmodule

//--- acc_top.sv
// Calibration coefficient registers of the sigma-delta converter, with correction path
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/100ps
`include "acc_regs.svh"
module acc_top #(
  parameter int RES_BITS = 24
) (
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_resetn,
  input  wire logic [`ACC_ADDR_W-1:0]    i_reg_addr,
  input  wire logic [`ACC_DATA_W-1:0]    i_reg_wdata,
  input  wire logic                      i_reg_wr,
  input  wire logic                      i_reg_rd,
  output logic      [`ACC_DATA_W-1:0]    o_reg_rdata,
  input  wire logic                      i_cal_done,
  input  wire acc_pkg::acc_cal_kind_type i_cal_kind,
  input  wire acc_pkg::acc_coef_type     i_cal_result,
  input  wire logic                      i_conv_valid,
  input  wire logic [RES_BITS-1:0]       i_conv_data,
  output logic                           o_corr_valid,
  output logic      [`ACC_COEF_W-1:0]    o_corr_data,
  output logic      [`ACC_COEF_W-1:0]    o_offset_coef,
  output logic      [`ACC_COEF_W-1:0]    o_gain_coef,
  output logic                           o_converter_error_flag,
  output logic                           o_irq
);

  // Coefficient storage
  acc_pkg::acc_coef_type offset_coef_q;
  acc_pkg::acc_coef_type gain_coef_q;
  acc_pkg::acc_coef_type offset_coef_d;
  acc_pkg::acc_coef_type gain_coef_d;

  // Status, clear and enable
  logic [`ACC_ST_W-1:0]   status_q;
  logic [`ACC_ST_W-1:0]   enable_q;
  logic [`ACC_ST_W-1:0]   status_set;
  logic [`ACC_ST_W-1:0]   status_clr;
  logic [`ACC_ST_W-1:0]   status_d;
  logic                   conv_err_q;

  // Bus decode
  logic                   wr_off;
  logic                   wr_gain;
  logic [1:0]             wr_byte_off;
  logic [1:0]             wr_byte_gain;
  logic                   wr_clear;
  logic                   wr_enable;
  logic [`ACC_DATA_W-1:0] rdata_d;

  // Calibration classification
  logic                   off_load;
  logic                   gain_load;
  logic                   off_err;
  logic                   gain_err;
  logic                   corr_sat;

  // Whole words reach the corrector, so a byte write is seen by the next sample
  acc_coef_if coef ();

  // Byte lane 0 is the high byte, matching the register order high, mid, low
  function automatic acc_pkg::acc_coef_type put_byte(input acc_pkg::acc_coef_type old,
                                                     input logic [1:0] idx,
                                                     input logic [`ACC_DATA_W-1:0] b);
    acc_pkg::acc_coef_type v;
    v = old;
    unique case (idx)
      `ACC_BYTE_HIGH: v[`ACC_LANE_HIGH_LSB +: `ACC_DATA_W] = b;
      `ACC_BYTE_MID:  v[`ACC_LANE_MID_LSB +: `ACC_DATA_W]  = b;
      `ACC_BYTE_LOW:  v[`ACC_LANE_LOW_LSB +: `ACC_DATA_W]  = b;
      default:        v        = old;
    endcase
    put_byte = v;
  endfunction

  function automatic logic [`ACC_DATA_W-1:0] get_byte(input acc_pkg::acc_coef_type c,
                                                      input logic [1:0] idx);
    logic [`ACC_DATA_W-1:0] b;
    b = '0;
    unique case (idx)
      `ACC_BYTE_HIGH: b = c[`ACC_LANE_HIGH_LSB +: `ACC_DATA_W];
      `ACC_BYTE_MID:  b = c[`ACC_LANE_MID_LSB +: `ACC_DATA_W];
      `ACC_BYTE_LOW:  b = c[`ACC_LANE_LOW_LSB +: `ACC_DATA_W];
      default:        b = '0;
    endcase
    get_byte = b;
  endfunction

  // A calibration result replaces the whole word and outranks a byte write in the
  // same cycle, because the sequencer's result reflects the present analog state
  function automatic acc_pkg::acc_coef_type coef_next(input acc_pkg::acc_coef_type old,
                                                      input logic load,
                                                      input acc_pkg::acc_coef_type result,
                                                      input logic wr,
                                                      input logic [1:0] idx,
                                                      input logic [`ACC_DATA_W-1:0] b);
    acc_pkg::acc_coef_type v;
    v = old;
    if (load) begin
      v = result;
    end else if (wr) begin
      v = put_byte(old, idx, b);
    end
    coef_next = v;
  endfunction

  // Only the two calibration-limit bits feed the general error flag; a saturated
  // corrected sample is reported through status alone
  function automatic logic has_cal_err(input logic [`ACC_ST_W-1:0] s);
    has_cal_err = s[`ACC_ST_OFF_ERR] || s[`ACC_ST_GAIN_ERR];
  endfunction

  // Write decode
  always_comb begin
    wr_off       = 1'b0;
    wr_gain      = 1'b0;
    wr_byte_off  = `ACC_BYTE_HIGH;
    wr_byte_gain = `ACC_BYTE_HIGH;
    wr_clear     = 1'b0;
    wr_enable    = 1'b0;
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        `ACC_OFS_OFF_HIGH: begin
          wr_off      = 1'b1;
          wr_byte_off = `ACC_BYTE_HIGH;
        end
        `ACC_OFS_OFF_MID: begin
          wr_off      = 1'b1;
          wr_byte_off = `ACC_BYTE_MID;
        end
        `ACC_OFS_OFF_LOW: begin
          wr_off      = 1'b1;
          wr_byte_off = `ACC_BYTE_LOW;
        end
        `ACC_OFS_GAIN_HIGH: begin
          wr_gain      = 1'b1;
          wr_byte_gain = `ACC_BYTE_HIGH;
        end
        `ACC_OFS_GAIN_MID: begin
          wr_gain      = 1'b1;
          wr_byte_gain = `ACC_BYTE_MID;
        end
        `ACC_OFS_GAIN_LOW: begin
          wr_gain      = 1'b1;
          wr_byte_gain = `ACC_BYTE_LOW;
        end
        `ACC_OFS_CLEAR: begin
          wr_clear = 1'b1;
        end
        `ACC_OFS_ENABLE: begin
          wr_enable = 1'b1;
        end
        default: begin
          wr_off  = 1'b0;
          wr_gain = 1'b0;
        end
      endcase
    end
  end

  // Classification is combinational so load, status and error flag share one edge
  acc_cal_check u_check (
    .i_done      (i_cal_done),
    .i_kind      (i_cal_kind),
    .i_result    (i_cal_result),
    .o_off_load  (off_load),
    .o_gain_load (gain_load),
    .o_off_err   (off_err),
    .o_gain_err  (gain_err)
  );

  // No byte waits in a holding register: each write shows at once, so software that
  // needs an atomic change keeps conversions away from its three byte writes
  always_comb begin
    offset_coef_d = coef_next(offset_coef_q, off_load, i_cal_result, wr_off, wr_byte_off,
                              i_reg_wdata);
    gain_coef_d   = coef_next(gain_coef_q, gain_load, i_cal_result, wr_gain, wr_byte_gain,
                              i_reg_wdata);
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      offset_coef_q <= `ACC_OFF_RESET;
    end else begin
      offset_coef_q <= offset_coef_d;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      gain_coef_q <= `ACC_GAIN_RESET;
    end else begin
      gain_coef_q <= gain_coef_d;
    end
  end

  assign coef.offset   = offset_coef_q;
  assign coef.gain     = gain_coef_q;
  assign o_offset_coef = offset_coef_q;
  assign o_gain_coef   = gain_coef_q;

  // Offset is taken with the raw sample and gain one edge later; a byte write in
  // between pairs the old offset with the new gain for that one sample
  acc_corrector #(
    .RES_BITS (RES_BITS)
  ) u_corr (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .coef      (coef),
    .i_valid   (i_conv_valid),
    .i_raw     (i_conv_data),
    .o_valid   (o_corr_valid),
    .o_data    (o_corr_data),
    .o_sat     (corr_sat)
  );

  // Sticky events; a set in the same cycle as its clear survives
  always_comb begin
    status_set = '0;
    status_set[`ACC_ST_CAL_DONE] = i_cal_done;
    status_set[`ACC_ST_OFF_ERR]  = off_err;
    status_set[`ACC_ST_GAIN_ERR] = gain_err;
    status_set[`ACC_ST_SAT]      = corr_sat;
    status_clr = '0;
    if (wr_clear) begin
      status_clr = i_reg_wdata[`ACC_ST_W-1:0];
    end
    status_d = (status_q & ~status_clr) | status_set;
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      status_q <= `ACC_ST_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  // Enable gates only the interrupt line; status bits collect events regardless
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      enable_q <= `ACC_ST_RESET;
    end else if (wr_enable) begin
      enable_q <= i_reg_wdata[`ACC_ST_W-1:0];
    end
  end

  // General error flag follows the two calibration-limit status bits; it reads the
  // next status so that it rises on the same edge as the bit that raises it
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      conv_err_q <= 1'b0;
    end else begin
      conv_err_q <= has_cal_err(status_d);
    end
  end

  assign o_converter_error_flag = conv_err_q;
  assign o_irq                  = |(status_q & enable_q);

  // Read mux; clear register and unmapped addresses read as zero
  // Status and enable sit in the low bits; the upper bits read as zero
  always_comb begin
    rdata_d = '0;
    unique case (i_reg_addr)
      `ACC_OFS_OFF_HIGH:  rdata_d = get_byte(offset_coef_q, `ACC_BYTE_HIGH);
      `ACC_OFS_OFF_MID:   rdata_d = get_byte(offset_coef_q, `ACC_BYTE_MID);
      `ACC_OFS_OFF_LOW:   rdata_d = get_byte(offset_coef_q, `ACC_BYTE_LOW);
      `ACC_OFS_GAIN_HIGH: rdata_d = get_byte(gain_coef_q, `ACC_BYTE_HIGH);
      `ACC_OFS_GAIN_MID:  rdata_d = get_byte(gain_coef_q, `ACC_BYTE_MID);
      `ACC_OFS_GAIN_LOW:  rdata_d = get_byte(gain_coef_q, `ACC_BYTE_LOW);
      `ACC_OFS_STATUS:    rdata_d = `ACC_DATA_W'(status_q);
      `ACC_OFS_ENABLE:    rdata_d = `ACC_DATA_W'(enable_q);
      default:            rdata_d = '0;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_reg_rdata <= '0;
    end else if (i_reg_rd) begin
      o_reg_rdata <= rdata_d;
    end else begin
      o_reg_rdata <= '0;
    end
  end

endmodule

//--- acc_top_assertions.sv
// Concurrent checks on the ports of the calibration coefficient block
`timescale 1ns/100ps
`include "acc_regs.svh"
module acc_top_assertions #(
  parameter int RES_BITS = 24
) (
  input wire logic                      i_sys_clk,
  input wire logic                      i_resetn,
  input wire logic [3:0]                i_reg_addr,
  input wire logic [7:0]                i_reg_wdata,
  input wire logic                      i_reg_wr,
  input wire logic                      i_reg_rd,
  input wire logic [7:0]                o_reg_rdata,
  input wire logic                      i_cal_done,
  input wire acc_pkg::acc_cal_kind_type i_cal_kind,
  input wire acc_pkg::acc_coef_type     i_cal_result,
  input wire logic                      i_conv_valid,
  input wire logic [RES_BITS-1:0]       i_conv_data,
  input wire logic                      o_corr_valid,
  input wire logic [23:0]               o_corr_data,
  input wire logic [23:0]               o_offset_coef,
  input wire logic [23:0]               o_gain_coef,
  input wire logic                      o_converter_error_flag,
  input wire logic                      o_irq
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  logic off_cal;
  logic gain_cal;
  assign off_cal  = i_cal_done && (i_cal_kind == acc_pkg::ACC_CAL_OFFSET);
  assign gain_cal = i_cal_done && (i_cal_kind == acc_pkg::ACC_CAL_GAIN);

  a_off_cal_load: assert property (
    off_cal |=> o_offset_coef == $past(i_cal_result)) else $error("offset not loaded");
  a_gain_cal_load: assert property (
    gain_cal |=> o_gain_coef == $past(i_cal_result)) else $error("gain not loaded");
  a_off_extreme_err: assert property (
    off_cal && (i_cal_result == `ACC_OFF_MAX || i_cal_result == `ACC_OFF_MIN)
    |=> o_converter_error_flag) else $error("offset extreme not flagged");
  a_gain_extreme_err: assert property (
    gain_cal && (i_cal_result == `ACC_GAIN_MIN || i_cal_result == `ACC_GAIN_MAX)
    |=> o_converter_error_flag) else $error("gain extreme not flagged");
  a_corr_two_cycles: assert property (
    i_conv_valid |-> ##2 o_corr_valid) else $error("corrected sample late");
  a_corr_has_cause: assert property (
    o_corr_valid |-> $past(i_conv_valid, 2)) else $error("corrected sample without input");
  a_unit_passthru: assert property (
    o_corr_valid && RES_BITS == 24 && $past(o_offset_coef, 2) == 24'h000000 &&
    $past(o_gain_coef) == `ACC_GAIN_RESET |-> o_corr_data == 24'($past(i_conv_data, 2)))
    else $error("unit gain changed the sample");
  a_coef_stable: assert property (
    !i_cal_done && !i_reg_wr |=> $stable(o_offset_coef) && $stable(o_gain_coef))
    else $error("coefficient changed on its own");
  a_read_off_high: assert property (
    i_reg_rd && i_reg_addr == `ACC_OFS_OFF_HIGH |=> o_reg_rdata == $past(o_offset_coef[23:16]))
    else $error("offset high byte read wrong");
  a_gain_low_write: assert property (
    i_reg_wr && i_reg_addr == `ACC_OFS_GAIN_LOW && !i_cal_done
    |=> o_gain_coef[7:0] == $past(i_reg_wdata)) else $error("gain low byte not written");

  c_off_err: cover property (off_cal ##1 o_converter_error_flag);
  c_corr: cover property (o_corr_valid);
  c_irq: cover property (o_irq);
endmodule

bind acc_top acc_top_assertions #(.RES_BITS(RES_BITS)) acc_top_assertions_i (
  .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata), .i_cal_done(i_cal_done), .i_cal_kind(i_cal_kind),
  .i_cal_result(i_cal_result), .i_conv_valid(i_conv_valid), .i_conv_data(i_conv_data),
  .o_corr_valid(o_corr_valid), .o_corr_data(o_corr_data), .o_offset_coef(o_offset_coef),
  .o_gain_coef(o_gain_coef), .o_converter_error_flag(o_converter_error_flag), .o_irq(o_irq));

//--- acc_top_tb.sv
// Self-checking bench for the calibration coefficient block
`timescale 1ns/100ps
`include "acc_regs.svh"
module acc_top_tb;
  logic                      clk;
  logic                      rstn;
  logic [3:0]                addr;
  logic [7:0]                wdata;
  logic                      wr;
  logic                      rd;
  logic [7:0]                rdata;
  logic                      cdone;
  acc_pkg::acc_cal_kind_type ckind;
  logic [23:0]               cres;
  logic                      cvalid;
  logic [23:0]               cdata;
  logic                      ovalid;
  logic [23:0]               odata;
  logic [23:0]               ocoef;
  logic [23:0]               gcoef;
  logic                      err;
  logic                      irq;
  int                        n_mismatch;
  int                        tests_run;
  int                        cycles;

  acc_top acc_top_i (
    .i_sys_clk(clk), .i_resetn(rstn), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_cal_done(cdone),
    .i_cal_kind(ckind), .i_cal_result(cres), .i_conv_valid(cvalid), .i_conv_data(cdata),
    .o_corr_valid(ovalid), .o_corr_data(odata), .o_offset_coef(ocoef), .o_gain_coef(gcoef),
    .o_converter_error_flag(err), .o_irq(irq));

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Whole run is about 140 cycles; the ceiling leaves ample margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'h1;
    @(posedge clk);
    wr    <= 1'h0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe, so sample right there
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'h1;
    @(posedge clk);
    rd   <= 1'h0;
    #1;
    chk({16'h0, rdata}, {16'h0, e});
  endtask

  task automatic set_coef(input logic [3:0] base, input logic [23:0] v);
    reg_wr(base, v[23:16]);
    reg_wr(base + 4'h1, v[15:8]);
    reg_wr(base + 4'h2, v[7:0]);
  endtask

  task automatic cal(input acc_pkg::acc_cal_kind_type k, input logic [23:0] r);
    @(posedge clk);
    cdone <= 1'h1;
    ckind <= k;
    cres  <= r;
    @(posedge clk);
    cdone <= 1'h0;
    #1;
  endtask

  task automatic conv(input logic [23:0] raw, input logic [23:0] exp);
    @(posedge clk);
    cvalid <= 1'h1;
    cdata  <= raw;
    @(posedge clk);
    cvalid <= 1'h0;
    @(posedge clk);
    #1;
    chk(24'(ovalid), 24'h1);
    chk(odata, exp);
  endtask

  task automatic t_reset();
    chk(ocoef, `ACC_OFF_RESET);
    chk(gcoef, `ACC_GAIN_RESET);
    chk({23'h0, err}, 24'h0);
    chk({23'h0, irq}, 24'h0);
    rdc(`ACC_OFS_STATUS, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_regs();
    set_coef(`ACC_OFS_OFF_HIGH, 24'h800001);
    chk(ocoef, 24'h800001);
    rdc(`ACC_OFS_OFF_HIGH, 8'h80);
    rdc(`ACC_OFS_OFF_MID, 8'h00);
    rdc(`ACC_OFS_OFF_LOW, 8'h01);
    set_coef(`ACC_OFS_GAIN_HIGH, 24'h940000);
    chk(gcoef, 24'h940000);
    rdc(`ACC_OFS_GAIN_HIGH, 8'h94);
    rdc(`ACC_OFS_GAIN_LOW, 8'h00);
    reg_wr(4'hf, 8'h5a);
    rdc(4'hf, 8'h00);
    reg_wr(`ACC_OFS_STATUS, 8'hff);
    rdc(`ACC_OFS_STATUS, 8'h00);
    rdc(`ACC_OFS_CLEAR, 8'h00);
    chk(gcoef, 24'h940000);
    $display("test registers done");
  endtask

  // Subtract-then-scale differs from scale-then-subtract on the two samples taken with gain 24'h940000
  task automatic t_correct();
    reg_wr(`ACC_OFS_CLEAR, 8'h0f);
    set_coef(`ACC_OFS_OFF_HIGH, 24'h000000);
    set_coef(`ACC_OFS_GAIN_HIGH, 24'h800000);
    conv(24'h000100, 24'h000100);
    set_coef(`ACC_OFS_OFF_HIGH, 24'h000010);
    set_coef(`ACC_OFS_GAIN_HIGH, 24'h940000);
    conv(24'h000110, 24'h000128);
    set_coef(`ACC_OFS_OFF_HIGH, 24'hfffff0);
    conv(24'h000000, 24'h000012);
    set_coef(`ACC_OFS_OFF_HIGH, 24'hffff00);
    set_coef(`ACC_OFS_GAIN_HIGH, 24'h800000);
    conv(24'h7fffff, 24'h7fffff);
    rdc(`ACC_OFS_STATUS, 8'h08);
    $display("test correction done");
  endtask

  // Status is cleared between entries so each error is judged alone
  task automatic t_cal();
    logic [25:0] tbl [6] = '{{1'h0, 24'h7fffff, 1'h1}, {1'h0, 24'h800000, 1'h1},
                             {1'h0, 24'h7ffffe, 1'h0}, {1'h1, 24'h000000, 1'h1},
                             {1'h1, 24'hffffff, 1'h1}, {1'h1, 24'h000001, 1'h0}};
    for (int i = 0; i < 6; i++) begin
      cal(acc_pkg::acc_cal_kind_type'(tbl[i][25]), tbl[i][24:1]);
      chk(tbl[i][25] ? gcoef : ocoef, tbl[i][24:1]);
      chk({23'h0, err}, {23'h0, tbl[i][0]});
      reg_wr(`ACC_OFS_CLEAR, 8'h0f);
      @(posedge clk);
      #1;
      chk({23'h0, err}, 24'h0);
    end
    $display("test calibration done");
  endtask

  task automatic t_irq();
    reg_wr(`ACC_OFS_ENABLE, 8'h01);
    rdc(`ACC_OFS_ENABLE, 8'h01);
    cal(acc_pkg::ACC_CAL_GAIN, 24'h400000);
    chk({23'h0, irq}, 24'h1);
    chk(ocoef, 24'h7ffffe);
    rdc(`ACC_OFS_STATUS, 8'h01);
    reg_wr(`ACC_OFS_ENABLE, 8'h02);
    chk({23'h0, irq}, 24'h0);
    reg_wr(`ACC_OFS_ENABLE, 8'h01);
    chk({23'h0, irq}, 24'h1);
    reg_wr(`ACC_OFS_CLEAR, 8'h01);
    chk({23'h0, irq}, 24'h0);
    $display("test interrupt done");
  endtask

  initial begin
    n_mismatch = 0;
    tests_run  = 0;
    cycles     = 0;
    rstn       = 1'h0;
    addr       = 4'h0;
    wdata      = 8'h00;
    wr         = 1'h0;
    rd         = 1'h0;
    cdone      = 1'h0;
    ckind      = acc_pkg::ACC_CAL_OFFSET;
    cres       = 24'h000000;
    cvalid     = 1'h0;
    cdata      = 24'h000000;
    repeat (2) @(posedge clk);
    rstn <= 1'h1;
    t_reset();
    t_regs();
    t_correct();
    t_cal();
    t_irq();
    tally_and_finish();
  end
endmodule
